// ===== rtl/sfh_regs.sv
`timescale 1ns/100ps
module sfh_regs
  import sfh_pkg::*;
#(
  parameter int          DEPTH    = 4,
  parameter logic [3:0]  REV_CODE = REV_CODE_DEF,
  parameter int          SCAN_W   = 12
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // host register port
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  output logic [31:0]                 reg_rdata,
  output logic                        reg_ack,
  // control bits held by control registers outside this block
  input  wire logic                   tx_loop_test,
  input  wire logic                   rx_loop_test,
  input  wire logic                   master_int_en,
  input  wire logic [EV_BITS-1:0]     event_int_en,
  input  wire logic [2:0]             aempty_level,
  input  wire logic [2:0]             afull_level,
  input  wire logic [SCAN_W-1:0]      scan_len,
  // switches
  input  wire logic [SW_BITS-1:0]     user_switch,
  // engine strobes
  input  wire logic                   bit_strobe,
  input  wire logic                   sync_upper,
  input  wire logic                   sync_lower,
  input  wire logic                   strobe_incoherent,
  input  wire logic                   msg_sent,
  input  wire logic                   uart_parity_err,
  input  wire logic                   uart_frame_err,
  input  wire logic                   uart_rx_char,
  input  wire logic                   uart_tx_done,
  // transmit engine drain
  output logic                        tx_data_valid,
  input  wire logic                   tx_data_take,
  output logic [31:0]                 tx_data,
  // receive engine fill
  input  wire logic                   rx_data_valid,
  output logic                        rx_data_ready,
  input  wire logic [31:0]            rx_data,
  // lines and interrupt
  output logic [GRP_BITS-1:0]         line_drive,
  output logic [GRP_BITS-1:0]         line_term,
  output logic                        sync_locked,
  output logic                        int_req
);
  localparam int CW = $clog2(DEPTH+1);

  ////////////////////////////////////////////////////////////////////////////
  // access decode
  wire hit_tx  = (reg_addr == ADDR_TX_FIFO);
  wire hit_rx  = (reg_addr == ADDR_RX_FIFO);
  wire wr_ev   = reg_wr && (reg_addr == ADDR_EVENT_LATCH);
  wire wr_dir  = reg_wr && (reg_addr == ADDR_DIR_TERM);

  ////////////////////////////////////////////////////////////////////////////
  // fifo a (transmit) and b (receive), each a store plus read holding register
  logic [1:0]        in_v, in_r, out_v, out_r;
  logic [31:0]       in_d [2];
  logic [31:0]       out_d [2];
  logic [CW-1:0]     cnt [2];
  logic [1:0]        hold_v_r;
  logic [31:0]       hold_d_r [2];
  logic [1:0]        writing_r;
  logic [1:0]        empty_f, aempty_f, half_f, afull_f, full_f, wr_rdy_f;
  logic [1:0]        aempty_q_r, afull_q_r;
  logic [1:0]        hold_take;

  // host writes go to a, or to b only in loop test; the engine fills b outside loop test
  assign in_v[0]  = reg_wr && hit_tx;
  assign in_d[0]  = reg_wdata;
  wire   host_b_wr = reg_wr && hit_rx && rx_loop_test;
  assign in_v[1]  = host_b_wr || (rx_data_valid && !rx_loop_test);
  assign in_d[1]  = host_b_wr ? reg_wdata : rx_data;
  assign rx_data_ready = in_r[1] && !rx_loop_test;

  // reads consume from the holding register: a in loop test, b always
  assign hold_take[0] = (reg_rd && hit_tx && tx_loop_test)
                        || (tx_data_take && !tx_loop_test);
  assign hold_take[1] = reg_rd && hit_rx;
  assign tx_data_valid = hold_v_r[0] && !tx_loop_test;
  assign tx_data       = hold_d_r[0];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_fifo
      sfh_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (in_v[g]),
        .in_ready  (in_r[g]),
        .in_data   (in_d[g]),
        .out_valid (out_v[g]),
        .out_ready (out_r[g]),
        .out_data  (out_d[g]),
        .count     (cnt[g])
      );
      // pre-read: holding register refills whenever empty or being taken
      assign out_r[g]    = !hold_v_r[g] || hold_take[g];
      assign empty_f[g]  = (cnt[g] == '0);
      assign full_f[g]   = (cnt[g] == CW'(DEPTH));
      assign half_f[g]   = (cnt[g] >= CW'(DEPTH/2));
      assign aempty_f[g] = (cnt[g] <= CW'(aempty_level));
      assign afull_f[g]  = (cnt[g] >= CW'(afull_level));
      assign wr_rdy_f[g] = !full_f[g] && !writing_r[g];

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          hold_v_r[g]   <= 1'b0;
          hold_d_r[g]   <= '0;
          writing_r[g]  <= 1'b0;
          aempty_q_r[g] <= 1'b1;
          // start high so a zero threshold gives no false crossing
          afull_q_r[g]  <= 1'b1;
        end else begin
          if (out_r[g]) begin
            hold_v_r[g] <= out_v[g];
          end
          if (out_r[g] && out_v[g]) begin
            hold_d_r[g] <= out_d[g];
          end
          writing_r[g]  <= in_v[g] && in_r[g];
          aempty_q_r[g] <= aempty_f[g];
          afull_q_r[g]  <= afull_f[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // sync lock tracking, counting bit strobes between syncs
  sfh_lock_t         lock_st_r;
  logic [SCAN_W-1:0] bit_cnt_r;
  logic [1:0]        hits_r;
  logic              lock_acq_p, lock_lost_p;
  wire               any_sync  = sync_upper || sync_lower;
  wire               scan_end  = bit_strobe && (bit_cnt_r == scan_len);
  wire               on_time   = any_sync && (bit_cnt_r == scan_len);

  assign lock_acq_p  = (lock_st_r == SFH_CONFIRM) && on_time
                       && (hits_r == 2'(LOCK_COUNT-1));
  assign lock_lost_p = (lock_st_r == SFH_LOCKED) && scan_end && !any_sync
                       && (hits_r == 2'(LOCK_COUNT-1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_st_r <= SFH_HUNT;
      bit_cnt_r <= '0;
      hits_r    <= '0;
    end else begin
      if (any_sync) begin
        bit_cnt_r <= '0;
      end else if (bit_strobe) begin
        bit_cnt_r <= scan_end ? '0 : bit_cnt_r + 1'b1;
      end
      case (lock_st_r)
        SFH_HUNT: begin
          if (any_sync) begin
            lock_st_r <= SFH_CONFIRM;
            hits_r    <= 2'd1;
          end
        end
        SFH_CONFIRM: begin
          if (lock_acq_p) begin
            lock_st_r <= SFH_LOCKED;
            hits_r    <= '0;
          end else if (on_time) begin
            hits_r <= hits_r + 2'd1;
          end else if (any_sync) begin
            hits_r <= 2'd1;
          end else if (scan_end) begin
            lock_st_r <= SFH_HUNT;
          end
        end
        SFH_LOCKED: begin
          if (any_sync) begin
            hits_r <= '0;
          end else if (lock_lost_p) begin
            lock_st_r <= SFH_HUNT;
            hits_r    <= '0;
          end else if (scan_end) begin
            hits_r <= hits_r + 2'd1;
          end
        end
        default: begin
          lock_st_r <= SFH_HUNT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky events: a new event wins over a clear in the same cycle
  logic [EV_BITS-1:0] ev_r, ev_set, ev_nxt;
  always_comb begin
    ev_set                = '0;
    ev_set[EV_A_AEMPTY]   = aempty_f[0] && !aempty_q_r[0];
    ev_set[EV_A_AFULL]    = afull_f[0] && !afull_q_r[0];
    ev_set[EV_B_AEMPTY]   = aempty_f[1] && !aempty_q_r[1];
    ev_set[EV_B_AFULL]    = afull_f[1] && !afull_q_r[1];
    ev_set[EV_UART_TXD]   = uart_tx_done;
    ev_set[EV_UART_AVAIL] = uart_rx_char;
    ev_set[EV_UART_FRAME] = uart_frame_err;
    ev_set[EV_UART_PAR]   = uart_parity_err;
    ev_set[EV_LO_SYNC]    = sync_lower;
    ev_set[EV_UP_SYNC]    = sync_upper;
    ev_set[EV_CLK_ERR]    = strobe_incoherent;
    ev_set[EV_LOCK_ACQ]   = lock_acq_p;
    ev_set[EV_LOCK_LOST]  = lock_lost_p;
    ev_set[EV_TX_DONE]    = msg_sent;
    ev_nxt = ev_set | (ev_r & ~(wr_ev ? reg_wdata[EV_BITS-1:0] : '0));
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data mux; reads of status leave every flag alone
  logic [31:0] live, rd_mux;
  logic [31:0] dir_term_r;
  wire         int_pend = |ev_r;

  always_comb begin
    live = '0;
    for (int f = 0; f < 2; f++) begin
      live[f*LS_FIFO_B_LO + LS_EMPTY]    = empty_f[f];
      live[f*LS_FIFO_B_LO + LS_AEMPTY]   = aempty_f[f];
      live[f*LS_FIFO_B_LO + LS_HALF]     = half_f[f];
      live[f*LS_FIFO_B_LO + LS_AFULL]    = afull_f[f];
      live[f*LS_FIFO_B_LO + LS_FULL]     = full_f[f];
      live[f*LS_FIFO_B_LO + LS_DATA_RDY] = hold_v_r[f];
      live[f*LS_FIFO_B_LO + LS_WR_RDY]   = wr_rdy_f[f];
    end
    live[LS_INT_PEND] = int_pend;
    case (reg_addr)
      ADDR_LIVE_STATUS: rd_mux = live;
      ADDR_SWITCH_REV:  rd_mux = {20'h0_0000, REV_CODE, user_switch};
      ADDR_EVENT_LATCH: rd_mux = {18'h0_0000, ev_r};
      ADDR_TX_FIFO:     rd_mux = tx_loop_test ? hold_d_r[0] : 32'h0000_0000;
      ADDR_RX_FIFO:     rd_mux = hold_d_r[1];
      ADDR_DIR_TERM:    rd_mux = dir_term_r;
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_r        <= '0;
      dir_term_r  <= DIR_TERM_RST;
      reg_rdata   <= 32'h0000_0000;
      reg_ack     <= 1'b0;
      line_drive  <= '0;
      line_term   <= '0;
      sync_locked <= 1'b0;
      int_req     <= 1'b0;
    end else begin
      ev_r    <= ev_nxt;
      reg_ack <= reg_wr || reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
      if (wr_dir) begin
        // only the defined group bits are kept; the rest read zero
        dir_term_r <= reg_wdata & {2'b00, {GRP_BITS{1'b1}}, 2'b00, {GRP_BITS{1'b1}}};
      end
      line_drive  <= dir_term_r[DIR_LSB +: GRP_BITS];
      line_term   <= dir_term_r[TERM_LSB +: GRP_BITS];
      sync_locked <= (lock_st_r == SFH_LOCKED);
      int_req     <= master_int_en && |(ev_r & event_int_en);
    end
  end
endmodule

// ===== rtl/sfh_pkg.sv
package sfh_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] ADDR_LIVE_STATUS = 8'h14;
  localparam logic [7:0] ADDR_SWITCH_REV  = 8'h18;
  localparam logic [7:0] ADDR_EVENT_LATCH = 8'h1c;
  localparam logic [7:0] ADDR_TX_FIFO     = 8'h20;
  localparam logic [7:0] ADDR_RX_FIFO     = 8'h24;
  localparam logic [7:0] ADDR_DIR_TERM    = 8'h28;

  //////////////////////////////////////////////////////////////////////////////
  // live status field positions, per fifo byte group, plus the fifo b group offset and the interrupt pending bit
  localparam int LS_EMPTY     = 0;
  localparam int LS_AEMPTY    = 1;
  localparam int LS_HALF      = 2;
  localparam int LS_AFULL     = 3;
  localparam int LS_FULL      = 4;
  localparam int LS_DATA_RDY  = 5;
  localparam int LS_WR_RDY    = 6;
  localparam int LS_FIFO_B_LO = 8;
  localparam int LS_INT_PEND  = 15;

  //////////////////////////////////////////////////////////////////////////////
  // event latch bit positions
  localparam int EV_A_AEMPTY   = 0;
  localparam int EV_A_AFULL    = 1;
  localparam int EV_B_AEMPTY   = 2;
  localparam int EV_B_AFULL    = 3;
  localparam int EV_UART_TXD   = 4;
  localparam int EV_UART_AVAIL = 5;
  localparam int EV_UART_FRAME = 6;
  localparam int EV_UART_PAR   = 7;
  localparam int EV_LO_SYNC    = 8;
  localparam int EV_UP_SYNC    = 9;
  localparam int EV_CLK_ERR    = 10;
  localparam int EV_LOCK_ACQ   = 11;
  localparam int EV_LOCK_LOST  = 12;
  localparam int EV_TX_DONE    = 13;
  localparam int EV_BITS       = 14;

  //////////////////////////////////////////////////////////////////////////////
  // switch port, direction/termination layout and counts
  localparam int SW_BITS       = 8;
  localparam int REV_BITS      = 4;
  localparam int DIR_LSB       = 0;
  localparam int TERM_LSB      = 16;
  localparam int GRP_BITS      = 14;
  localparam int LOCK_COUNT    = 3;
  localparam logic [31:0] DIR_TERM_RST = 32'h0000_0000;
  localparam logic [3:0]  REV_CODE_DEF = 4'h5; // arbitrary value

  typedef enum logic [1:0] {
    SFH_HUNT,
    SFH_CONFIRM,
    SFH_LOCKED
  } sfh_lock_t;

endpackage

// ===== rtl/sfh_fifo.sv
`timescale 1ns/100ps
module sfh_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // fill side
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  // drain side
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  // occupancy of the store
  output logic [$clog2(DEPTH+1)-1:0]    count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [CW-1:0]    cnt_r;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (cnt_r != CW'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];
  assign count     = cnt_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end
endmodule

// ===== bench/sfh_regs_props.sv
`timescale 1ns/100ps
module sfh_regs_props
  import sfh_pkg::*;
#(
  parameter logic [3:0] REV_CODE = REV_CODE_DEF
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // host register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_ack,
  // controls, engines and lines
  input wire logic        tx_loop_test,
  input wire logic        rx_loop_test,
  input wire logic        master_int_en,
  input wire logic [7:0]  user_switch,
  input wire logic        tx_data_valid,
  input wire logic        rx_data_ready,
  input wire logic [13:0] line_drive,
  input wire logic [13:0] line_term,
  input wire logic        sync_locked,
  input wire logic        int_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  property p_ack; (reg_wr || reg_rd) |=> reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack after access");
  property p_no_ack; !(reg_wr || reg_rd) |=> !reg_ack; endproperty
  a_no_ack: assert property (p_no_ack) else $error("ack without access");
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_int; int_req |-> $past(master_int_en); endproperty
  a_int: assert property (p_int) else $error("interrupt without master enable");
  property p_rev;
    reg_rd && reg_addr == ADDR_SWITCH_REV |=> reg_rdata == {20'h0, REV_CODE, $past(user_switch)};
  endproperty
  a_rev: assert property (p_rev) else $error("switch port wrong");
  property p_txblk;
    reg_rd && reg_addr == ADDR_TX_FIFO && !tx_loop_test |=> reg_rdata == 32'h0;
  endproperty
  a_txblk: assert property (p_txblk) else $error("tx port read leaked");
  property p_txv; tx_loop_test |-> !tx_data_valid; endproperty
  a_txv: assert property (p_txv) else $error("engine fed in loop test");
  property p_rxr; rx_loop_test |-> !rx_data_ready; endproperty
  a_rxr: assert property (p_rxr) else $error("engine filled in loop test");
  property p_dir;
    reg_wr && reg_addr == ADDR_DIR_TERM |=> ##1 (line_drive == $past(reg_wdata[13:0], 2)
      && line_term == $past(reg_wdata[29:16], 2));
  endproperty
  a_dir: assert property (p_dir) else $error("line control wrong");
  c_int: cover property ($rose(int_req));
  c_lock: cover property ($rose(sync_locked));
  c_rxw: cover property (reg_wr && reg_addr == ADDR_RX_FIFO && rx_loop_test);
endmodule

// ===== bench/sfh_host.sv
`timescale 1ns/100ps
module sfh_host (
  // clock
  input  wire logic        clk,
  // register bus
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [7:0]       reg_addr,
  output logic [31:0]      reg_wdata,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_ack
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
  end
  // whole 32-bit word per access; a one-edge request as the port takes it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic k);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_wdata <= ~d;
    @(posedge clk);
    k = reg_ack;
    q = reg_rdata;
  endtask
endmodule

// ===== bench/sfh_regs_tb.sv
`timescale 1ns/100ps
module sfh_regs_tb;
  import sfh_pkg::*;
  localparam int D = 4;
  localparam int L = 4;
  logic        clk = 1'b0, rst = 1'b1, reg_wr, reg_rd, reg_ack;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, tx_data, rx_data = '0;
  logic        tx_loop_test = 0, rx_loop_test = 0, master_int_en = 0, bit_strobe = 0;
  logic        tx_data_take = 0, rx_data_valid = 0;
  logic [13:0] event_int_en = '0, line_drive, line_term, ev_m = '0;
  logic [2:0]  aempty_level, afull_level;
  logic [11:0] scan_len = 12'h004;
  logic [7:0]  user_switch = '0, ev_p = '0;
  logic        tx_data_valid, rx_data_ready, sync_locked, int_req;
  wire         sync_upper, sync_lower, strobe_incoherent, msg_sent;
  wire         uart_parity_err, uart_frame_err, uart_rx_char, uart_tx_done;
  int          seed = 84, n_mismatch = 0, n_checks = 0, c, h, eb;
  int          evb[8] = '{EV_TX_DONE, EV_CLK_ERR, EV_UART_PAR, EV_UART_FRAME,
                          EV_UART_AVAIL, EV_UART_TXD, EV_UP_SYNC, EV_LO_SYNC};
  assign {sync_lower, sync_upper, uart_tx_done, uart_rx_char, uart_frame_err,
          uart_parity_err, strobe_incoherent, msg_sent} = ev_p;
  sfh_regs i_sfh_regs (.*);
  sfh_host i_host (.*);
  always #2 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    logic k;
    i_host.xfer(w, a, d, q, k);
    chk("reg_ack", 32'(k), 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    acc(1'b0, a, 32'h0, q);
  endtask
  // pulses end off the edge so lock state is read settled
  task automatic pulse(input logic [7:0] m);
    @(posedge clk) ev_p <= m;
    @(posedge clk) ev_p <= '0;
    @(negedge clk);
  endtask
  task automatic strobe(input int n);
    repeat (n) begin
      @(posedge clk) bit_strobe <= 1'b1;
      @(posedge clk) bit_strobe <= 1'b0;
    end
    @(negedge clk);
  endtask
  task automatic clr;
    logic [31:0] v;
    wr(ADDR_EVENT_LATCH, 32'h0000_3fff);
    ev_m = '0;
    rd(ADDR_EVENT_LATCH, v);
    chk("events cleared", v, 32'h0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // store count only, except data ready, which follows the holding word
  function automatic logic [6:0] st(input int n, input int k);
    return {n < D, k == 1, n == D, n >= afull_level, n >= D / 2,
            n <= aempty_level, n == 0};
  endfunction
  task automatic mv(input int n);
    if (n >= afull_level && c < afull_level) ev_m[eb+1] = 1'b1;
    if (n <= aempty_level && c > aempty_level) ev_m[eb] = 1'b1;
    c = n;
  endtask
  task automatic stat(input int sh);
    logic [31:0] v;
    rd(ADDR_LIVE_STATUS, v);
    chk("fifo flags", 32'(v[sh+:7]), 32'(st(c, h)));
    rd(ADDR_EVENT_LATCH, v);
    chk("fifo events", 32'(v[eb+:2]), 32'(ev_m[eb+:2]));
  endtask
  task automatic fifo_t(input int s);
    logic [31:0] q[$];
    logic [7:0]  a;
    logic [31:0] w, v;
    int          sh;
    a = s ? ADDR_RX_FIFO : ADDR_TX_FIFO;
    sh = s ? LS_FIFO_B_LO : LS_EMPTY;
    eb = s ? EV_B_AEMPTY : EV_A_AEMPTY;
    c = 0;
    h = 0;
    if (s) wr(a, 32'h1234_5678);
    else begin
      rd(a, v);
      chk("tx port", v, 32'h0);
    end
    stat(sh);
    @(posedge clk);
    if (s) rx_loop_test <= 1'b1;
    else tx_loop_test <= 1'b1;
    // one write beyond full is dropped
    repeat (D + 2) begin
      w = $random(seed);
      wr(a, w);
      if (c < D) begin
        q.push_back(w);
        if (h) mv(c + 1);
        else begin
          mv(1);
          mv(0);
          h = 1;
        end
      end
      stat(sh);
    end
    while (q.size() > 0) begin
      rd(a, v);
      chk("fifo word", v, q.pop_front());
      if (c > 0) mv(c - 1);
      else h = 0;
      stat(sh);
    end
    @(posedge clk);
    tx_loop_test <= 1'b0;
    rx_loop_test <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v, w;
    int          i;
    aempty_level = 3'($random(seed));
    afull_level = 3'($random(seed));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    fifo_t(0);
    fifo_t(1);
    w = $random(seed);
    wr(ADDR_TX_FIFO, w);
    repeat (2) @(posedge clk);
    #1;
    chk("tx valid", 32'(tx_data_valid), 32'h1);
    chk("tx data", tx_data, w);
    @(posedge clk) tx_data_take <= 1'b1;
    @(posedge clk) tx_data_take <= 1'b0;
    rx_data_valid <= 1'b1;
    rx_data <= ~w;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (rx_data_ready !== 1'b1 && i < 20);
    chk("rx ready", 32'(rx_data_ready), 32'h1);
    @(posedge clk) rx_data_valid <= 1'b0;
    rx_data <= w;
    repeat (3) @(posedge clk);
    rd(ADDR_RX_FIFO, v);
    chk("rx word", v, ~w);
    chk("tx drained", 32'(tx_data_valid), 32'h0);
    clr();
    repeat (24) begin
      i = $unsigned($random(seed)) % 8;
      pulse(8'h01 << i);
      ev_m[evb[i]] = 1'b1;
      rd(ADDR_EVENT_LATCH, v);
      chk("events", v, {18'h0, ev_m});
      rd(ADDR_LIVE_STATUS, v);
      chk("pending", 32'(v[LS_INT_PEND]), 32'(|ev_m));
      event_int_en <= 14'($random(seed));
      master_int_en <= 1'($random(seed));
      repeat (3) @(posedge clk);
      chk("int_req", 32'(int_req), 32'(master_int_en & |(ev_m & event_int_en)));
      w = $random(seed);
      wr(ADDR_EVENT_LATCH, w);
      ev_m = ev_m & ~w[13:0];
    end
    clr();
    i = 0;
    while (sync_locked !== 1'b1 && i < 4) begin
      strobe(L);
      pulse(8'hc0);
      i++;
    end
    ev_m = 14'h0b00;
    chk("locked", 32'(sync_locked), 32'h1);
    strobe(2 * L);
    chk("still locked", 32'(sync_locked), 32'h1);
    strobe(2 * L);
    chk("lock lost", 32'(sync_locked), 32'h0);
    ev_m[EV_LOCK_LOST] = 1'b1;
    rd(ADDR_EVENT_LATCH, v);
    chk("lock events", v, {18'h0, ev_m});
    repeat (4) begin
      w = $random(seed);
      wr(ADDR_DIR_TERM, w);
      @(posedge clk) user_switch <= 8'($random(seed));
      rd(ADDR_DIR_TERM, v);
      chk("dir term", v, w & 32'h3fff_3fff);
      chk("lines", {2'b0, line_term, 2'b0, line_drive}, w & 32'h3fff_3fff);
      rd(ADDR_SWITCH_REV, v);
      chk("switch", v, {20'h0, REV_CODE_DEF, user_switch});
    end
    rd(8'h00, v);
    chk("unmapped", v, 32'h0);
    end_of_test();
  end
  // far longer than the sequence needs
  initial begin
    #40000;
    n_mismatch++;
    end_of_test();
  end
endmodule
bind sfh_regs sfh_regs_props #(.REV_CODE(REV_CODE)) i_sfh_regs_props (.*);
